// *** src/clk_pwr_pkg.sv ***
// Shared constants for the system clock and power mode controller.
// Assumes one 25 MHz clock; oscillators appear as synchronous tick inputs.
`default_nettype none

package clk_pwr_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] SYS_CTRL_OFF  = 8'h00;
	localparam logic [7:0] FRC_CTRL_OFF  = 8'h04;
	localparam logic [7:0] XTAL_CTRL_OFF = 8'h08;
	localparam logic [7:0] WDOG_CTRL_OFF = 8'h0C;
	localparam logic [7:0] MODE_STAT_OFF = 8'h10;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SEL_LSB      = 5;
	localparam int HSRC_BIT     = 3;
	localparam int LSRC_BIT     = 2;
	localparam int HKEEP_BIT    = 1;
	localparam int LKEEP_BIT    = 0;
	localparam int FRC_FREQ_LSB = 2;
	localparam int FLAG_BIT     = 1;
	localparam int EN_BIT       = 0;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [7:0] SYS_CTRL_RST = 8'h00;
	localparam logic [1:0] FRC_FREQ_RST = 2'h0;
	localparam logic       FRC_EN_RST   = 1'b1;
	localparam logic       XTAL_EN_RST  = 1'b0;
	localparam logic       WDOG_EN_RST  = 1'b0;
	localparam logic [2:0] SEL_SUB      = 3'h7;
	localparam logic [1:0] FREQ_8M      = 2'h0;
	localparam logic [1:0] FREQ_12M     = 2'h1;
	localparam logic [1:0] FREQ_16M     = 2'h2;
	localparam logic [1:0] FREQ_8M_ALT  = 2'h3;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ----------------------------------------
	// Settling counts, in oscillator ticks
	// ----------------------------------------
	localparam logic [9:0] FRC_SETTLE_TICKS  = 10'h020;
	localparam logic [9:0] XTAL_SETTLE_TICKS = 10'h100;

	typedef enum logic [2:0] {
		MODE_FAST      = 3'b000,
		MODE_SLOW      = 3'b001,
		MODE_SLEEP     = 3'b010,
		MODE_IDLE_LOW  = 3'b011,
		MODE_IDLE_BOTH = 3'b100,
		MODE_IDLE_HIGH = 3'b101
	} mode_e;

endpackage

`default_nettype wire

// *** src/osc_settle.sv ***
// Stability flag for one oscillator, counted in its own ticks.
// Assumes tick only pulses while the oscillator is commanded to run.
`timescale 1ns/1ns
`default_nettype none

module osc_settle #(
	parameter logic [9:0] SETTLE = 10'h010
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic ce,
	input  wire logic run,
	input  wire logic restart,
	input  wire logic tick,
	output var  logic stable_q
);

	logic [9:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_q    <= 10'h000;
			stable_q <= 1'b0;
		end else if (ce) begin
			if (!run || restart) begin
				cnt_q    <= 10'h000;
				stable_q <= 1'b0;
			end else if (tick && !stable_q) begin
				cnt_q    <= cnt_q + 10'h001;
				stable_q <= (cnt_q == SETTLE - 10'h001);
			end
		end
	end

	restart_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
		(ce && (restart || !run)) |=> !stable_q)
		else $error("stable flag not cleared on restart");

endmodule

`default_nettype wire

// *** src/sys_tick_divider.sv ***
// Divides the high-speed tick stream and picks it or the sub clock.
// Assumes ticks are one-cycle pulses; a new selection waits for a period end unless the current source is dead.
`timescale 1ns/1ns
`default_nettype none

module sys_tick_divider (
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       high_tick,
	input  wire logic       sub_tick,
	input  wire logic       high_live,
	input  wire logic       sub_live,
	input  wire logic [2:0] sel,
	output var  logic       sys_tick,
	output var  logic [2:0] active_sel_q
);

	logic [5:0] cnt_q;
	logic [5:0] mask;
	logic       sub_act;
	logic       boundary;

	always_comb begin
		sub_act  = (active_sel_q == clk_pwr_pkg::SEL_SUB);
		mask     = 6'((7'h01 << active_sel_q) - 7'h01);
		sys_tick = sub_act ? sub_tick : (high_tick && cnt_q == mask);
		// A dead source would never reach a period end, so it may be left at once
		boundary = sys_tick || (sub_act ? !sub_live : !high_live);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_q        <= 6'h00;
			active_sel_q <= 3'h0;
		end else if (ce) begin
			if (boundary && sel != active_sel_q) begin
				active_sel_q <= sel;
				cnt_q        <= 6'h00;
			end else if (high_tick && !sub_act) begin
				cnt_q <= (cnt_q == mask) ? 6'h00 : cnt_q + 6'h01;
			end
		end
	end

	switch_at_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
		(ce && active_sel_q != $past(active_sel_q)) |-> $past(boundary))
		else $error("clock selection changed mid period");

	div_count_range_a: assert property (@(posedge clk_sys) disable iff (srst)
		!sub_act |-> cnt_q <= mask)
		else $error("divider count beyond ratio");

endmodule

`default_nettype wire

// *** src/clk_pwr_ctrl.sv ***
// System clock selection and power operating modes, AXI4-Lite registers.
// Assumes oscillator ticks and CPU halt/wake pulses are synchronous to clk_sys.
//
// How it works
// - Select system clock source from sys_clk_select.
// - Codes 000-110 divide high clock 1..64.
// - Code 111 runs from sub clock.
// - High clock from crystal or fast RC.
// - Sub clock only from slow RC.
// - In slow mode high oscillator follows enable.
// - Two run modes, four halted modes.
// - Halt, both keeps low: sleep.
// - Sleep keeps slow RC only for watchdog.
// - Halt, low keep only: idle_low_only.
// - Halt, both keeps: idle_both.
// - Halt, high keep only: idle_high_only.
// - Frequency code 00/01/10/11: 8/12/16/8 MHz.
// - high_src_select 0 fast RC, 1 crystal.
// - Stable flag cleared on enable or change.
`timescale 1ns/1ns
`default_nettype none

module clk_pwr_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output var  logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	input  wire logic        halt_req,
	input  wire logic        wake_req,
	input  wire logic        fast_rc_tick,
	input  wire logic        crystal_tick,
	input  wire logic        slow_rc_tick,
	output var  logic        fast_rc_run_q,
	output var  logic        crystal_run_q,
	output var  logic        slow_rc_run_q,
	output var  logic [1:0]  fast_rc_trim_q,
	output var  logic        cpu_clk_en_q,
	output var  logic        periph_clk_en_q,
	output var  logic [2:0]  op_mode_q
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	clk_pwr_pkg::mode_e mode_q;
	logic [7:0]  sys_ctrl_q;
	logic [1:0]  frc_freq_q;
	logic        frc_en_q;
	logic        xtal_en_q;
	logic        wd_en_q;
	logic        frc_restart;
	logic        frc_stable;
	logic        xtal_stable;
	logic        high_src;
	logic        high_live;
	logic        high_tick;
	logic        sub_tick;
	logic        sys_tick;
	logic [2:0]  active_sel;
	logic        run_mode;
	logic        high_keep_mode;
	logic        aw_held_q;
	logic        w_held_q;
	logic [7:0]  aw_addr_q;
	logic [7:0]  w_byte_q;
	logic        w_lane_q;
	logic        do_write;
	logic [31:0] rd_data;
	logic        rd_hit;

	// ----------------------------------------
	// Clock sources
	// ----------------------------------------
	always_comb begin
		high_src       = sys_ctrl_q[clk_pwr_pkg::HSRC_BIT];
		high_live      = high_src ? xtal_stable : frc_stable;
		// Unsettled oscillators are held back so the divider never sees a bad edge
		high_tick      = high_src ? (crystal_tick && xtal_stable) : (fast_rc_tick && frc_stable);
		sub_tick       = slow_rc_tick && slow_rc_run_q;
		run_mode       = (mode_q == clk_pwr_pkg::MODE_FAST) || (mode_q == clk_pwr_pkg::MODE_SLOW);
		high_keep_mode = (mode_q == clk_pwr_pkg::MODE_IDLE_BOTH) || (mode_q == clk_pwr_pkg::MODE_IDLE_HIGH);
	end

	osc_settle #(
		.SETTLE (clk_pwr_pkg::FRC_SETTLE_TICKS)
	) u_frc_settle (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.ce       (ce),
		.run      (fast_rc_run_q),
		.restart  (frc_restart),
		.tick     (fast_rc_tick),
		.stable_q (frc_stable)
	);

	osc_settle #(
		.SETTLE (clk_pwr_pkg::XTAL_SETTLE_TICKS)
	) u_xtal_settle (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.ce       (ce),
		.run      (crystal_run_q),
		.restart  (1'b0),
		.tick     (crystal_tick),
		.stable_q (xtal_stable)
	);

	sys_tick_divider u_div (
		.clk_sys      (clk_sys),
		.srst         (srst),
		.ce           (ce),
		.high_tick    (high_tick),
		.sub_tick     (sub_tick),
		.high_live    (high_live),
		.sub_live     (slow_rc_run_q),
		.sel          (sys_ctrl_q[clk_pwr_pkg::SEL_LSB +: 3]),
		.sys_tick     (sys_tick),
		.active_sel_q (active_sel)
	);

	// ----------------------------------------
	// Oscillator run enables
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fast_rc_run_q <= 1'b0;
			crystal_run_q <= 1'b0;
			slow_rc_run_q <= 1'b0;
		end else if (ce) begin
			// Selected source is forced on in fast and high-keep idle modes; in those and slow mode enables rule, sleep and low idle stop it
			fast_rc_run_q <= (frc_en_q && (run_mode || high_keep_mode))
				|| (!high_src && (mode_q == clk_pwr_pkg::MODE_FAST || high_keep_mode));
			crystal_run_q <= (xtal_en_q && (run_mode || high_keep_mode))
				|| (high_src && (mode_q == clk_pwr_pkg::MODE_FAST || high_keep_mode));
			slow_rc_run_q <= run_mode || (mode_q == clk_pwr_pkg::MODE_IDLE_LOW)
				|| (mode_q == clk_pwr_pkg::MODE_IDLE_BOTH)
				|| (mode_q == clk_pwr_pkg::MODE_SLEEP && wd_en_q);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fast_rc_trim_q <= clk_pwr_pkg::FREQ_8M;
		end else if (ce) begin
			case (frc_freq_q)
				clk_pwr_pkg::FREQ_12M:    fast_rc_trim_q <= clk_pwr_pkg::FREQ_12M;
				clk_pwr_pkg::FREQ_16M:    fast_rc_trim_q <= clk_pwr_pkg::FREQ_16M;
				clk_pwr_pkg::FREQ_8M_ALT: fast_rc_trim_q <= clk_pwr_pkg::FREQ_8M;
				default:                  fast_rc_trim_q <= clk_pwr_pkg::FREQ_8M;
			endcase
		end
	end

	// ----------------------------------------
	// Operating mode
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_q <= clk_pwr_pkg::MODE_FAST;
		end else if (ce) begin
			case (mode_q)
				clk_pwr_pkg::MODE_FAST,
				clk_pwr_pkg::MODE_SLOW: begin
					if (halt_req) begin
						case ({sys_ctrl_q[clk_pwr_pkg::HKEEP_BIT], sys_ctrl_q[clk_pwr_pkg::LKEEP_BIT]})
							2'b00:   mode_q <= clk_pwr_pkg::MODE_SLEEP;
							2'b01:   mode_q <= clk_pwr_pkg::MODE_IDLE_LOW;
							2'b11:   mode_q <= clk_pwr_pkg::MODE_IDLE_BOTH;
							default: mode_q <= clk_pwr_pkg::MODE_IDLE_HIGH;
						endcase
					end else begin
						mode_q <= (active_sel == clk_pwr_pkg::SEL_SUB) ? clk_pwr_pkg::MODE_SLOW
							: clk_pwr_pkg::MODE_FAST;
					end
				end
				clk_pwr_pkg::MODE_SLEEP,
				clk_pwr_pkg::MODE_IDLE_LOW,
				clk_pwr_pkg::MODE_IDLE_BOTH,
				clk_pwr_pkg::MODE_IDLE_HIGH: begin
					if (wake_req) begin
						mode_q <= (active_sel == clk_pwr_pkg::SEL_SUB) ? clk_pwr_pkg::MODE_SLOW
							: clk_pwr_pkg::MODE_FAST;
					end
				end
				default: mode_q <= clk_pwr_pkg::MODE_FAST;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cpu_clk_en_q    <= 1'b0;
			periph_clk_en_q <= 1'b0;
			op_mode_q       <= 3'h0;
		end else if (ce) begin
			op_mode_q       <= mode_q;
			cpu_clk_en_q    <= sys_tick && run_mode;
			periph_clk_en_q <= sys_tick && (run_mode || mode_q == clk_pwr_pkg::MODE_IDLE_BOTH
				|| (mode_q == clk_pwr_pkg::MODE_IDLE_LOW && active_sel == clk_pwr_pkg::SEL_SUB)
				|| (mode_q == clk_pwr_pkg::MODE_IDLE_HIGH && active_sel != clk_pwr_pkg::SEL_SUB));
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	always_comb begin
		do_write    = aw_held_q && w_held_q && !s_axi_bvalid;
		frc_restart = do_write && w_lane_q && aw_addr_q == clk_pwr_pkg::FRC_CTRL_OFF
			&& w_byte_q[clk_pwr_pkg::FRC_FREQ_LSB +: 2] != frc_freq_q;
		rd_hit  = 1'b1;
		rd_data = 32'h0000_0000;
		case (s_axi_araddr)
			clk_pwr_pkg::SYS_CTRL_OFF:  rd_data[7:0] = sys_ctrl_q;
			clk_pwr_pkg::FRC_CTRL_OFF:  rd_data[3:0] = {frc_freq_q, frc_stable, frc_en_q};
			clk_pwr_pkg::XTAL_CTRL_OFF: rd_data[1:0] = {xtal_stable, xtal_en_q};
			clk_pwr_pkg::WDOG_CTRL_OFF: rd_data[0]   = wd_en_q;
			clk_pwr_pkg::MODE_STAT_OFF: rd_data[5:0] = {active_sel, mode_q};
			default:                    rd_hit       = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= clk_pwr_pkg::RESP_OKAY;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_byte_q      <= 8'h00;
			w_lane_q      <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q     <= 1'b1;
				w_byte_q     <= s_axi_wdata[7:0];
				w_lane_q     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_q == clk_pwr_pkg::SYS_CTRL_OFF || aw_addr_q == clk_pwr_pkg::FRC_CTRL_OFF
					|| aw_addr_q == clk_pwr_pkg::XTAL_CTRL_OFF || aw_addr_q == clk_pwr_pkg::WDOG_CTRL_OFF
					|| aw_addr_q == clk_pwr_pkg::MODE_STAT_OFF) ? clk_pwr_pkg::RESP_OKAY : clk_pwr_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held_q     <= 1'b0;
				w_held_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= clk_pwr_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_data;
				s_axi_rresp   <= rd_hit ? clk_pwr_pkg::RESP_OKAY : clk_pwr_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sys_ctrl_q <= clk_pwr_pkg::SYS_CTRL_RST;
			frc_freq_q <= clk_pwr_pkg::FRC_FREQ_RST;
			frc_en_q   <= clk_pwr_pkg::FRC_EN_RST;
			xtal_en_q  <= clk_pwr_pkg::XTAL_EN_RST;
			wd_en_q    <= clk_pwr_pkg::WDOG_EN_RST;
		end else if (ce && do_write && w_lane_q) begin
			case (aw_addr_q)
				// Bit 4 unimplemented; low-source select has only one legal value
				clk_pwr_pkg::SYS_CTRL_OFF:  sys_ctrl_q <= {w_byte_q[7:5], 1'b0, w_byte_q[3], 1'b0, w_byte_q[1:0]};
				clk_pwr_pkg::FRC_CTRL_OFF: begin
					frc_freq_q <= w_byte_q[clk_pwr_pkg::FRC_FREQ_LSB +: 2];
					frc_en_q   <= w_byte_q[clk_pwr_pkg::EN_BIT];
				end
				clk_pwr_pkg::XTAL_CTRL_OFF: xtal_en_q <= w_byte_q[clk_pwr_pkg::EN_BIT];
				clk_pwr_pkg::WDOG_CTRL_OFF: wd_en_q   <= w_byte_q[clk_pwr_pkg::EN_BIT];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	sequence halt_taken;
		ce && run_mode && halt_req;
	endsequence

	halt_sleep_a: assert property (halt_taken ##0 !sys_ctrl_q[1] && !sys_ctrl_q[0] |=> mode_q == clk_pwr_pkg::MODE_SLEEP)
		else $error("halt with no keep bits missed sleep");
	idle_low_a: assert property (halt_taken ##0 !sys_ctrl_q[1] && sys_ctrl_q[0] |=> mode_q == clk_pwr_pkg::MODE_IDLE_LOW)
		else $error("wrong mode for low keep");
	idle_both_a: assert property (halt_taken ##0 sys_ctrl_q[1] && sys_ctrl_q[0] |=> mode_q == clk_pwr_pkg::MODE_IDLE_BOTH)
		else $error("wrong mode for both keeps");
	idle_high_a: assert property (halt_taken ##0 sys_ctrl_q[1] && !sys_ctrl_q[0] |=> mode_q == clk_pwr_pkg::MODE_IDLE_HIGH)
		else $error("wrong mode for high keep");
	sleep_osc_off_a: assert property (ce && mode_q == clk_pwr_pkg::MODE_SLEEP
		|=> !fast_rc_run_q && !crystal_run_q && slow_rc_run_q == $past(wd_en_q))
		else $error("oscillator left running in sleep");
	slow_high_osc_a: assert property (ce && mode_q == clk_pwr_pkg::MODE_SLOW |=> fast_rc_run_q == $past(frc_en_q))
		else $error("fast RC run does not follow its enable in slow mode");
	cpu_halt_a: assert property (ce && !run_mode |=> !cpu_clk_en_q)
		else $error("CPU clocked while halted");
	periph_gate_a: assert property (ce && mode_q == clk_pwr_pkg::MODE_IDLE_LOW
		&& active_sel != clk_pwr_pkg::SEL_SUB |=> !periph_clk_en_q)
		else $error("peripheral clock in low idle from high source");
	sub_source_a: assert property (ce && run_mode && active_sel == clk_pwr_pkg::SEL_SUB
		|=> cpu_clk_en_q == $past(slow_rc_tick && slow_rc_run_q))
		else $error("slow mode not clocked from sub clock");

endmodule

`default_nettype wire

// *** tb/osc_model.sv ***
// Oscillator tick model standing at the controller's far side.
// Assumes run commands are registered levels on clk_sys.
`timescale 1ns/1ns
`default_nettype none

module osc_model #(
	parameter int FRC_P = 2,
	parameter int XT_P  = 3,
	parameter int SRC_P = 20
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic fr_run,
	input  wire logic xt_run,
	input  wire logic sr_run,
	output var  logic fr_tick,
	output var  logic xt_tick,
	output var  logic sr_tick
);
	// ----
	// Tick counters
	// ----
	// Ticks stop at once when run drops, as a real oscillator would
	int fc, xc, sc;
	always_ff @(posedge clk_sys) begin
		fc <= (srst || !fr_run || fc == FRC_P - 1) ? 0 : fc + 1;
		fr_tick <= !srst && fr_run && fc == FRC_P - 1;
		xc <= (srst || !xt_run || xc == XT_P - 1) ? 0 : xc + 1;
		xt_tick <= !srst && xt_run && xc == XT_P - 1;
	end
	always_ff @(posedge clk_sys) begin
		sc <= (srst || !sr_run || sc == SRC_P - 1) ? 0 : sc + 1;
		sr_tick <= !srst && sr_run && sc == SRC_P - 1;
	end
endmodule

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the clock and power mode controller.
// Assumes osc_model feeds all three oscillator tick inputs.
`timescale 1ns/1ns
`default_nettype none

module tb;
	localparam logic [7:0] SYS  = clk_pwr_pkg::SYS_CTRL_OFF;
	localparam logic [7:0] FRC  = clk_pwr_pkg::FRC_CTRL_OFF;
	localparam logic [7:0] XTL  = clk_pwr_pkg::XTAL_CTRL_OFF;
	localparam logic [7:0] WDG  = clk_pwr_pkg::WDOG_CTRL_OFF;
	localparam logic [7:0] STA  = clk_pwr_pkg::MODE_STAT_OFF;
	localparam int         XT_P = 3;
	localparam int         SR_P = 20;
	logic        clk_sys, srst, awvalid, wvalid, bready, arvalid, rready, halt_req, wake_req;
	logic        awready, wready, bvalid, arready, rvalid, fr_t, xt_t, sr_t, fr_r, xt_r, sr_r;
	logic        cpu_en, per_en, ce;
	logic [3:0]  strb;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, trim, rs;
	logic [2:0]  mode;
	int          err_count, n_checks, g;
	// Halt cases: keep high, keep low, select, watchdog, mode, peripheral clock
	logic [9:0]  tab [7] = '{10'h014, 10'h0E4, 10'h1E7, 10'h106, 10'h309, 10'h20B, 10'h2EA};

	clk_pwr_ctrl u_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.halt_req(halt_req), .wake_req(wake_req), .fast_rc_tick(fr_t), .crystal_tick(xt_t),
		.slow_rc_tick(sr_t), .fast_rc_run_q(fr_r), .crystal_run_q(xt_r), .slow_rc_run_q(sr_r),
		.fast_rc_trim_q(trim), .cpu_clk_en_q(cpu_en), .periph_clk_en_q(per_en), .op_mode_q(mode));

	osc_model #(.FRC_P(2), .XT_P(XT_P), .SRC_P(SR_P)) u_osc (.clk_sys(clk_sys), .srst(srst),
		.fr_run(fr_r), .xt_run(xt_r), .sr_run(sr_r), .fr_tick(fr_t), .xt_tick(xt_t), .sr_tick(sr_t));

	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic hang(input int n);
		if (n >= 2000) begin
			err_count++;
			$display("Error %0t: wait timed out", $time);
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		awvalid <= 1'h1;
		awaddr <= a;
		wvalid <= 1'h1;
		wdata <= {24'h0, d};
		bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && n < 2000);
		hang(n);
		rs = bresp;
		bready <= 1'h0;
	endtask

	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
			if (arvalid && arready)
				arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && n < 2000);
		hang(n);
		rd = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask

	// Third pulse gap only: the first two may straddle a source change
	task automatic gap;
		repeat (3) begin
			g = 0;
			do begin
				@(posedge clk_sys);
				g++;
			end while (cpu_en !== 1'h1 && g < 2000);
			hang(g);
		end
	endtask

	task automatic settle(input logic [7:0] a);
		int n;
		n = 0;
		do begin
			rdr(a);
			n++;
		end while (rd[1] !== 1'h1 && n < 2000);
		hang(n);
	endtask

	task automatic pulse_in(input logic h);
		@(posedge clk_sys);
		if (h)
			halt_req <= 1'h1;
		else
			wake_req <= 1'h1;
		@(posedge clk_sys);
		halt_req <= 1'h0;
		wake_req <= 1'h0;
		repeat (3) @(posedge clk_sys);
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		rdr(SYS);
		chk(rd, 32'h0);
		rdr(STA);
		chk(rd, 32'h0);
		rdr(8'h14);
		chk(rs, clk_pwr_pkg::RESP_SLVERR);
		chk(fr_r, 1'h1);
		wr(SYS, 8'h00);
		chk(rs, clk_pwr_pkg::RESP_OKAY);
		wr(8'h14, 8'hFF);
		chk(rs, clk_pwr_pkg::RESP_SLVERR);
		// Lane 0 strobe off: write answered but must not land
		strb <= 4'h0;
		wr(SYS, 8'hFF);
		strb <= 4'hF;
		chk(rs, clk_pwr_pkg::RESP_OKAY);
		rdr(SYS);
		chk(rd, 32'h0);
	endtask

	// Clock enable low freezes the CPU clock pulse train
	task automatic t_freeze;
		logic v;
		int   k;
		ce <= 1'h0;
		@(posedge clk_sys);
		v = cpu_en;
		k = 0;
		repeat (100) begin
			@(posedge clk_sys);
			k += (cpu_en !== v);
		end
		chk(k, 0);
		chk(mode, clk_pwr_pkg::MODE_SLOW);
		ce <= 1'h1;
		gap();
		chk(g, SR_P);
	endtask

	task automatic t_freq;
		logic [1:0] c;
		settle(FRC);
		for (int i = 1; i < 5; i++) begin
			c = i[1:0];
			wr(FRC, {4'h0, c, 2'h1});
			rdr(FRC);
			chk(rd[1], 1'h0);
			chk(trim, (c == 2'h3) ? 2'h0 : c);
		end
		settle(FRC);
	endtask

	task automatic t_div;
		for (int s = 0; s < 7; s++) begin
			wr(SYS, {s[2:0], 5'h0});
			gap();
			chk(g, 2 << s);
			rdr(STA);
			chk(rd[5:0], {s[2:0], clk_pwr_pkg::MODE_FAST});
		end
	endtask

	task automatic t_slow;
		wr(SYS, 8'hE0);
		gap();
		chk(g, SR_P);
		chk(mode, clk_pwr_pkg::MODE_SLOW);
		chk(fr_r, 1'h1);
		wr(FRC, 8'h00);
		repeat (3) @(posedge clk_sys);
		chk(fr_r, 1'h0);
		wr(FRC, 8'h01);
		wr(SYS, 8'h00);
		settle(FRC);
	endtask

	task automatic t_xtal;
		wr(XTL, 8'h01);
		wr(SYS, 8'h08);
		gap();
		chk(g, XT_P);
		chk(xt_r, 1'h1);
		wr(SYS, 8'h00);
		wr(XTL, 8'h00);
	endtask

	task automatic t_halt;
		logic [9:0] e;
		int c, p;
		for (int i = 0; i < 7; i++) begin
			e = tab[i];
			wr(WDG, {7'h0, e[4]});
			wr(SYS, {e[7:5], 3'h0, e[9], e[8]});
			repeat (200) @(posedge clk_sys);
			pulse_in(1'h1);
			chk(mode, e[3:1]);
			chk(fr_r, e[9]);
			chk(sr_r, e[8] | e[4]);
			c = 0;
			p = 0;
			repeat (300) begin
				@(posedge clk_sys);
				c += (cpu_en === 1'h1);
				p += (per_en === 1'h1);
			end
			chk(c, 0);
			chk(p > 0, e[0]);
			pulse_in(1'h0);
			chk(mode, (e[7:5] == 3'h7) ? clk_pwr_pkg::MODE_SLOW : clk_pwr_pkg::MODE_FAST);
		end
	endtask

	// ----
	// Clock, reset and sequence
	// ----
	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	initial begin
		srst = 1'h1;
		ce = 1'h1;
		strb = 4'hF;
		awvalid = 1'h0;
		wvalid = 1'h0;
		bready = 1'h0;
		arvalid = 1'h0;
		rready = 1'h0;
		halt_req = 1'h0;
		wake_req = 1'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (16) @(posedge clk_sys);
		srst <= 1'h0;
		t_reset();
		t_freq();
		t_div();
		t_slow();
		t_xtal();
		t_halt();
		t_freeze();
		close_out();
	end
endmodule

`default_nettype wire
